// ==== bench/csp_host_model.sv ====
`timescale 1ns/1ps
// Host on the register port: one request per call, then an idle cycle.
module csp_host_model (
	input  wire logic                          clk,
	input  wire logic [csp_pkg::DATA_W-1:0]    rdata,
	input  wire logic                          rvalid,
	output csp_pkg::csp_req_t                  req
);
	initial req = '0;

	// Enter just after an edge; the read answer shows in the cycle after the request.
	// Each call makes exactly one register access.
	task automatic acc(input logic w, input logic [csp_pkg::ADDR_W-1:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic v);
		req = '{w, !w, a, d};
		@(posedge clk);
		#1 req = '0;
		q = rdata;
		v = rvalid;
		@(posedge clk);
		#1;
	endtask : acc
endmodule : csp_host_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
// Integer model of staged and active registers, compared with the controls before and after each update of the modes test and at set checkpoints.
module tb_top;
	logic                   clk = 0;
	logic                   rst_n = 0;
	logic                   vt = 0;
	logic                   et = 0;
	logic [7:0]             rdata;
	logic                   rvalid;
	logic                   cal_start;
	logic                   dist_tick;
	logic                   booted;
	logic [7:0]             q;
	logic                   v;
	csp_pkg::csp_req_t      req;
	csp_pkg::csp_clk_ctrl_t ctrl;
	int                     check_count = 0;
	int                     fail_count = 0;
	int                     n;
	int                     stg[5] = '{1, 0, 0, 0, 0};
	int                     act[5] = '{1, 0, 0, 0, 0};
	localparam logic [9:0]  ADR[5] = '{csp_pkg::OFS_PLL_CTRL, csp_pkg::OFS_CAL_CTRL,
		csp_pkg::OFS_REF_EN, csp_pkg::OFS_VCO_DIV, csp_pkg::OFS_SRC_SEL};

	always #2.5 clk = ~clk;

	// The on-chip oscillator ticks at random; it must only count when selected.
	always @(posedge clk) begin
		#1 vt = 1'($urandom);
	end

	csp_host_model u_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
	csp_clock_cfg u_dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
		.vco_tick(vt), .ext_tick(et), .ctrl(ctrl), .cal_start(cal_start), .dist_tick(dist_tick),
		.booted(booted));

	// Expected controls from the active model.
	function automatic csp_pkg::csp_clk_ctrl_t expc();
		logic on;
		int c;
		on = act[0][1:0] == 0;
		c = act[3] & 7;
		expc = '{!on, on, on && act[4][1], act[4][1], on && !act[4][1], act[4][0], act[0][7],
			act[2][2:0], 3'(c < 5 ? c + 2 : 1)};
	endfunction : expc

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		u_host.acc(1'b1, a, d, q, v);
		for (int k = 0; k < 5; k++) if (ADR[k] == a) stg[k] = d;
		if (a == csp_pkg::OFS_UPDATE && d[0]) act = stg;
	endtask : wr

	task automatic rd(input logic [9:0] a, input int e);
		u_host.acc(1'b0, a, 8'h00, q, v);
		`CHK("rvalid", 1'b1, v)
		`CHK("rdata", 8'(e), q)
	endtask : rd

	task automatic do_reset();
		rst_n = 0;
		repeat (16) @(posedge clk);
		#1 rst_n = 1;
		n = 0;
		while (booted !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		`CHK("booted", 1'b1, booted)
	endtask : do_reset

	// Counts distribution ticks over 60 cycles of a steady external source.
	task automatic ticks(input int e);
		et = 1;
		repeat (8) @(posedge clk);
		n = 0;
		repeat (60) begin
			@(posedge clk);
			#1 n += dist_tick;
		end
		et = 0;
		`CHK("dist_ticks", e, n)
	endtask : ticks

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	initial begin
		#100000;
		fail_count++;
		test_done();
	end

	initial begin
		void'($urandom(32'h611f));
		do_reset();
		`CHK("ctrl", expc(), ctrl)
		for (int k = 0; k < 5; k++) rd(ADR[k], stg[k]);
		rd(csp_pkg::OFS_UPDATE, 0);
		$display("test defaults done");
		for (int t = 0; t < 24; t++) begin
			for (int k = 0; k < 5; k++) wr(ADR[k], 8'($urandom));
			if (t < 8) wr(csp_pkg::OFS_VCO_DIV, 8'(t));
			`CHK("ctrl_held", expc(), ctrl)
			for (int k = 0; k < 5; k++) rd(ADR[k], stg[k]);
			wr(csp_pkg::OFS_UPDATE, 8'h01);
			`CHK("ctrl", expc(), ctrl)
			rd(csp_pkg::OFS_UPDATE, 0);
		end
		wr(10'h3ff, 8'hff);
		rd(10'h3ff, 0);
		`CHK("ctrl_unmapped", expc(), ctrl)
		$display("test modes done");
		wr(csp_pkg::OFS_SRC_SEL, 8'h02);
		wr(csp_pkg::OFS_PLL_CTRL, 8'h00);
		wr(csp_pkg::OFS_CAL_CTRL, 8'h00);
		wr(csp_pkg::OFS_UPDATE, 8'h01);
		for (int c = 0; c < 2; c++) begin
			if (c > 0) wr(csp_pkg::OFS_CAL_CTRL, 8'h00);
			if (c > 0) wr(csp_pkg::OFS_UPDATE, 8'h01);
			wr(csp_pkg::OFS_CAL_CTRL, 8'h01);
			wr(csp_pkg::OFS_UPDATE, 8'h01);
			`CHK("cal_start", 1'b1, cal_start)
			@(posedge clk);
			#1 `CHK("cal_pulse", 1'b0, cal_start)
		end
		$display("test calibration done");
		wr(csp_pkg::OFS_SRC_SEL, 8'h00);
		for (int c = 0; c < 8; c++) begin
			wr(csp_pkg::OFS_VCO_DIV, 8'(c));
			wr(csp_pkg::OFS_UPDATE, 8'h01);
			ticks(60 / (c < 5 ? c + 2 : 1));
		end
		wr(csp_pkg::OFS_VCO_DIV, 8'h00); // Ratio 2, so a bypass that fails halves the count.
		wr(csp_pkg::OFS_SRC_SEL, 8'h01);
		wr(csp_pkg::OFS_UPDATE, 8'h01);
		ticks(60);
		$display("test divider done");
		wr(csp_pkg::OFS_NV_CTRL, 8'h01);
		do_reset();
		stg = act;
		`CHK("ctrl_restored", expc(), ctrl)
		for (int k = 0; k < 5; k++) rd(ADR[k], stg[k]);
		u_host.acc(1'b0, csp_pkg::OFS_NV_CTRL, 8'h00, q, v);
		`CHK("nv_valid", 1'b1, q[0])
		$display("test storage done");
		test_done();
	end
endmodule : tb_top

// ==== core/csp_clock_cfg.sv ====
`timescale 1ns/1ps
// Clock source, PLL power and VCO divider configuration with staged registers.
module csp_clock_cfg (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire csp_pkg::csp_req_t          req,
	output logic [csp_pkg::DATA_W-1:0]      rdata,
	output logic                            rvalid,
	input  wire logic                       vco_tick,
	input  wire logic                       ext_tick,
	output csp_pkg::csp_clk_ctrl_t          ctrl,
	output logic                            cal_start,
	output logic                            dist_tick,
	output logic                            booted
);
	logic [1:0]             rst_sync_q;
	logic                   rst_int_n;
	csp_pkg::csp_main_st_t  s_q;
	csp_pkg::csp_main_st_t  s_d;
	csp_pkg::csp_cfg_t      nv_cfg_q;
	logic [7:0]             nv_sig_q = '0; // Blank storage reads as zero at power-up.
	logic                   nv_ok;
	logic                   src_tick;
	logic                   div_tick;
	logic                   upd_wr;

	// Reset is asserted at once and released through two flops.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_int_n = rst_sync_q[1];

	// nonvolatile save
	// Storage has no reset so it survives chip reset; the signature guards against blank contents.
	always_ff @(posedge clk) begin
		if (s_q.nv_save) begin
			nv_cfg_q <= s_q.active;
			nv_sig_q <= csp_pkg::NV_SIG;
		end
	end
	assign nv_ok = (nv_sig_q == csp_pkg::NV_SIG);

	// Active control fields, all taken from flops.
	always_comb begin
		ctrl.pll_on = (s_q.active.pll_ctrl[csp_pkg::PLL_PWR_LSB +: 2] == csp_pkg::PLL_NORMAL);
		ctrl.pll_pd = !ctrl.pll_on;
		ctrl.vco_sel = s_q.active.src_sel[csp_pkg::SRC_VCO_BIT];
		ctrl.vco_on = ctrl.pll_on && ctrl.vco_sel;
		ctrl.ext_to_prescaler = ctrl.pll_on && !ctrl.vco_sel;
		ctrl.div_bypass = s_q.active.src_sel[csp_pkg::BYPASS_BIT];
		ctrl.pfd_neg = s_q.active.pll_ctrl[csp_pkg::PFD_POL_BIT];
		ctrl.ref_en = s_q.active.ref_en[csp_pkg::REF_EN_LSB +: 3];
		ctrl.vco_ratio = csp_pkg::csp_div_ratio(s_q.active.vco_div[csp_pkg::VCO_DIV_LSB +: 3]);
	end

	// A stopped internal VCO yields no ticks, so only a running one can drive distribution.
	assign src_tick = ctrl.vco_sel ? (vco_tick && ctrl.vco_on) : ext_tick;
	assign upd_wr = req.wr && (req.addr == csp_pkg::OFS_UPDATE) && req.wdata[csp_pkg::UPDATE_BIT];

	csp_tick_div u_div (
		.clk      (clk),
		.rst_n    (rst_int_n),
		.in_tick  (src_tick),
		.ratio    (ctrl.vco_ratio),
		.out_tick (div_tick)
	);

	// Boot load, register writes, update transfer and readback.
	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;
		s_d.cal_start = 1'b0;
		s_d.nv_save = 1'b0;
		s_d.rdata = s_q.rdata;
		s_d.cal_q = s_q.active.cal_ctrl[csp_pkg::CAL_BIT];
		s_d.dist_tick = ctrl.div_bypass ? src_tick : div_tick;
		case (s_q.phase)
			csp_pkg::ST_BOOT: begin
				s_d.stage = nv_ok ? nv_cfg_q : csp_pkg::CFG_RESET;
				s_d.active = s_d.stage;
				s_d.phase = csp_pkg::ST_RUN;
			end
			csp_pkg::ST_RUN: begin
				if (req.wr) begin
					case (req.addr)
						csp_pkg::OFS_PLL_CTRL: s_d.stage.pll_ctrl = req.wdata;
						csp_pkg::OFS_CAL_CTRL: s_d.stage.cal_ctrl = req.wdata;
						csp_pkg::OFS_REF_EN:   s_d.stage.ref_en = req.wdata;
						csp_pkg::OFS_VCO_DIV:  s_d.stage.vco_div = req.wdata;
						csp_pkg::OFS_SRC_SEL:  s_d.stage.src_sel = req.wdata;
						csp_pkg::OFS_NV_CTRL:  s_d.nv_save = req.wdata[csp_pkg::NV_SAVE_BIT];
						default: ;
					endcase
				end
				if (upd_wr) begin
					s_d.active = s_q.stage;
				end
				s_d.cal_start = s_q.active.cal_ctrl[csp_pkg::CAL_BIT] && !s_q.cal_q;
				if (req.rd) begin
					s_d.rvalid = 1'b1;
					case (req.addr)
						csp_pkg::OFS_PLL_CTRL: s_d.rdata = s_q.stage.pll_ctrl;
						csp_pkg::OFS_CAL_CTRL: s_d.rdata = s_q.stage.cal_ctrl;
						csp_pkg::OFS_REF_EN:   s_d.rdata = s_q.stage.ref_en;
						csp_pkg::OFS_VCO_DIV:  s_d.rdata = s_q.stage.vco_div;
						csp_pkg::OFS_SRC_SEL:  s_d.rdata = s_q.stage.src_sel;
						csp_pkg::OFS_NV_CTRL:  s_d.rdata = {7'h00, nv_ok};
						default:               s_d.rdata = csp_pkg::RST_ZERO;
					endcase
				end
			end
			default: s_d.phase = csp_pkg::ST_BOOT;
		endcase
	end

	// State register; staged and active sets both start at the defaults.
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			s_q <= '{csp_pkg::ST_BOOT, csp_pkg::CFG_RESET, csp_pkg::CFG_RESET, 1'b0, csp_pkg::RST_ZERO,
				1'b0, 1'b0, 1'b0, 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign rvalid = s_q.rvalid;
	assign cal_start = s_q.cal_start;
	assign dist_tick = s_q.dist_tick;
	assign booted = (s_q.phase == csp_pkg::ST_RUN);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_int_n);

	sequence s_upd;
		(s_q.phase == csp_pkg::ST_RUN) && upd_wr;
	endsequence

	sequence s_boot_blank;
		(s_q.phase == csp_pkg::ST_BOOT) && !nv_ok;
	endsequence

	// Calibration arms when an update raises the active calibration bit.
	sequence s_cal_arm;
		s_upd ##0 (s_q.stage.cal_ctrl[csp_pkg::CAL_BIT] && !s_q.active.cal_ctrl[csp_pkg::CAL_BIT]);
	endsequence

	property p_pll_pd;
		(s_upd and (s_q.stage.pll_ctrl[csp_pkg::PLL_PWR_LSB +: 2] == csp_pkg::PLL_ASYNC_PD)) |=>
			ctrl.pll_pd && !ctrl.pll_on;
	endproperty
	a_pll_pd: assert property (p_pll_pd) else $error("PLL not powered down after update");

	property p_src_sel;
		(s_upd and s_q.stage.src_sel[csp_pkg::SRC_VCO_BIT]) |=> ctrl.vco_sel;
	endproperty
	a_src_sel: assert property (p_src_sel) else $error("VCO not selected after update");

	property p_bypass;
		(booted && ctrl.div_bypass && src_tick) |=> dist_tick;
	endproperty
	a_bypass: assert property (p_bypass) else $error("Bypassed tick not passed through");

	property p_pfd;
		(s_upd and s_q.stage.pll_ctrl[csp_pkg::PFD_POL_BIT]) |=> ctrl.pfd_neg ##1 (ctrl.pfd_neg || $past(upd_wr));
	endproperty
	a_pfd: assert property (p_pfd) else $error("Polarity not applied");

	property p_defaults;
		s_boot_blank |=> ctrl.pll_pd && !ctrl.vco_sel && !ctrl.div_bypass && (ctrl.vco_ratio == csp_pkg::RATIO_RESET);
	endproperty
	a_defaults: assert property (p_defaults) else $error("Reset defaults wrong");

	property p_ratio;
		booted |-> (ctrl.vco_ratio >= 3'h1) && (ctrl.vco_ratio <= 3'h6);
	endproperty
	a_ratio: assert property (p_ratio) else $error("Divider ratio out of range");

	property p_vco_off;
		(ctrl.pll_on && !ctrl.vco_sel) |-> !ctrl.vco_on && ctrl.ext_to_prescaler;
	endproperty
	a_vco_off: assert property (p_vco_off) else $error("Internal VCO on with external input");

	property p_restore;
		((s_q.phase == csp_pkg::ST_BOOT) && nv_ok) |=> (s_q.active == $past(nv_cfg_q));
	endproperty
	a_restore: assert property (p_restore) else $error("Stored configuration not restored");

	property p_ref_off;
		s_boot_blank |=> (ctrl.ref_en == 3'h0);
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("Reference input enabled by default");

	property p_update;
		s_upd |=> (s_q.active == $past(s_q.stage));
	endproperty
	a_update: assert property (p_update) else $error("Update did not transfer staged set");

	property p_cal_start;
		s_cal_arm |=> ##1 cal_start ##1 !cal_start;
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("Calibration start not a single pulse");

	property p_upd_read;
		(booted && req.rd && (req.addr == csp_pkg::OFS_UPDATE)) |=> rvalid && (rdata == csp_pkg::RST_ZERO);
	endproperty
	a_upd_read: assert property (p_upd_read) else $error("Update strobe did not read back as zero");

	property p_vco_idle;
		(booted && ctrl.vco_sel && !ctrl.vco_on && ctrl.div_bypass) |=> !dist_tick;
	endproperty
	a_vco_idle: assert property (p_vco_idle) else $error("Stopped VCO reached distribution");
endmodule : csp_clock_cfg

// ==== core/csp_pkg.sv ====
// Contract
// - A PLL power field of 00b runs the PLL and 01b puts it into asynchronous power-down.
// - The source-select bit routes the internal VCO onward when 1 and the external clock input when 0.
// - The divider-bypass bit feeds distribution through the VCO divider when 0 and around it when 1.
// - The polarity bit selects positive phase-detector polarity at 0 and negative polarity at 1.
// - After reset the PLL is powered down, the divider code is 000b (divide by 2), the divider is used and the external clock is selected.
// - The three-bit divider code gives division by 1, 2, 3, 4, 5 or 6.
// - With the PLL on and the external input selected, the internal VCO is off and the external clock feeds the prescaler.
// - In the default routing the external input, up to 2400 MHz, is divided before the channel dividers.
// - The configuration can be saved in nonvolatile storage and is restored at power-up without host action.
// - All reference inputs are disabled by default and must be enabled explicitly.
package csp_pkg;

	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;

	// Register offsets.
	localparam logic [ADDR_W-1:0] OFS_PLL_CTRL = 10'h010;
	localparam logic [ADDR_W-1:0] OFS_CAL_CTRL = 10'h018;
	localparam logic [ADDR_W-1:0] OFS_REF_EN   = 10'h01c;
	localparam logic [ADDR_W-1:0] OFS_VCO_DIV  = 10'h1e0;
	localparam logic [ADDR_W-1:0] OFS_SRC_SEL  = 10'h1e1;
	localparam logic [ADDR_W-1:0] OFS_UPDATE   = 10'h232;
	localparam logic [ADDR_W-1:0] OFS_NV_CTRL  = 10'h2f0;

	// Field positions.
	localparam int PLL_PWR_LSB = 0;
	localparam int PFD_POL_BIT = 7;
	localparam int CAL_BIT     = 0;
	localparam int REF_EN_LSB  = 0;
	localparam int VCO_DIV_LSB = 0;
	localparam int BYPASS_BIT  = 0;
	localparam int SRC_VCO_BIT = 1;
	localparam int UPDATE_BIT  = 0;
	localparam int NV_SAVE_BIT = 0;

	// Power field codes.
	localparam logic [1:0] PLL_NORMAL   = 2'h0;
	localparam logic [1:0] PLL_ASYNC_PD = 2'h1;

	// Reset values.
	localparam logic [DATA_W-1:0] RST_PLL_CTRL = 8'h01;
	localparam logic [DATA_W-1:0] RST_ZERO     = 8'h00;
	localparam logic [2:0]        RATIO_RESET  = 3'h2;

	// Marks stored contents as valid; the value is arbitrary.
	localparam logic [DATA_W-1:0] NV_SIG = 8'ha5;

	typedef struct packed {
		logic [DATA_W-1:0] pll_ctrl;
		logic [DATA_W-1:0] cal_ctrl;
		logic [DATA_W-1:0] ref_en;
		logic [DATA_W-1:0] vco_div;
		logic [DATA_W-1:0] src_sel;
	} csp_cfg_t;

	localparam csp_cfg_t CFG_RESET = '{RST_PLL_CTRL, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} csp_req_t;

	typedef struct packed {
		logic       pll_pd;
		logic       pll_on;
		logic       vco_on;
		logic       vco_sel;
		logic       ext_to_prescaler;
		logic       div_bypass;
		logic       pfd_neg;
		logic [2:0] ref_en;
		logic [2:0] vco_ratio;
	} csp_clk_ctrl_t;

	typedef enum logic {ST_BOOT, ST_RUN} csp_phase_t;

	typedef struct packed {
		csp_phase_t        phase;
		csp_cfg_t          stage;
		csp_cfg_t          active;
		logic              cal_q;
		logic [DATA_W-1:0] rdata;
		logic              rvalid;
		logic              cal_start;
		logic              nv_save;
		logic              dist_tick;
	} csp_main_st_t;

	typedef struct packed {
		logic [2:0] cnt;
		logic       out;
	} csp_div_st_t;

	// Divider code to ratio: 000b..100b give 2..6, the rest give 1.
	function automatic logic [2:0] csp_div_ratio(input logic [2:0] code);
		case (code)
			3'h0: csp_div_ratio = 3'h2;
			3'h1: csp_div_ratio = 3'h3;
			3'h2: csp_div_ratio = 3'h4;
			3'h3: csp_div_ratio = 3'h5;
			3'h4: csp_div_ratio = 3'h6;
			default: csp_div_ratio = 3'h1;
		endcase
	endfunction : csp_div_ratio

endpackage : csp_pkg

// ==== core/csp_tick_div.sv ====
`timescale 1ns/1ps
// Divides a stream of source ticks by a ratio of 1 to 6.
module csp_tick_div (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       in_tick,
	input  wire logic [2:0] ratio,
	output logic            out_tick
);
	csp_pkg::csp_div_st_t s_q;
	csp_pkg::csp_div_st_t s_d;

	// Count source ticks and emit one per full ratio; a ratio change takes effect at once, from the next source tick.
	always_comb begin
		s_d = s_q;
		s_d.out = 1'b0;
		if (in_tick) begin
			if (s_q.cnt >= 3'(ratio - 3'h1)) begin
				s_d.cnt = 3'h0;
				s_d.out = 1'b1;
			end else begin
				s_d.cnt = 3'(s_q.cnt + 3'h1);
			end
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign out_tick = s_q.out;
endmodule : csp_tick_div
